/* verilog/srw_pkg.sv */
package srw_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] SRW_OFS_CFG = 8'h00;
  localparam logic [7:0] SRW_OFS_TIMER = 8'h04;
  localparam logic [7:0] SRW_OFS_CONST = 8'h08;
  localparam logic [7:0] SRW_OFS_CTRL = 8'h0C;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int SRW_WRW_LSB = 3;
  localparam int SRW_WRW_MSB = 4;
  localparam int SRW_CKS_LSB = 3;
  localparam int SRW_CKS_MSB = 5;
  localparam int SRW_FLAG_BIT = 7;
  localparam int SRW_KEY_LSB = 16;
  localparam int SRW_CNT_MSB = 7;
  localparam logic [15:0] SRW_TIMER_KEY = 16'hA55A;
  localparam logic [1:0] SRW_WRW_RST = 2'h0;
  localparam logic [2:0] SRW_CKS_RST = 3'h0;
  localparam logic [2:0] SRW_CKS_STOP = 3'h0;
  localparam logic [7:0] SRW_CNT_RST = 8'h00;
  localparam logic [7:0] SRW_CNT_MAX = 8'hFF;
  localparam logic [7:0] SRW_CONST_RST = 8'hFF;
  localparam logic [31:0] SRW_RD_NONE = 32'h0000_0000;
  localparam int SRW_HTRANS_ACT_BIT = 1;

  // Prescaler masks per clock select code; code 0 stops the timer
  localparam logic [7:0][11:0] SRW_PRE_MASK = {
    12'hFFF, 12'h7FF, 12'h3FF, 12'h0FF, 12'h03F, 12'h00F, 12'h003, 12'h000
  };

  // ****************************************
  // Memory commands
  // ****************************************
  localparam logic [2:0] SRW_OP_NOP = 3'h0;
  localparam logic [2:0] SRW_OP_ACTIVATE = 3'h1;
  localparam logic [2:0] SRW_OP_WRITE = 3'h2;
  localparam logic [2:0] SRW_OP_WRITE_AP = 3'h3;
  localparam logic [2:0] SRW_OP_PRECHARGE = 3'h4;
  localparam logic [2:0] SRW_OP_READ = 3'h5;
  localparam logic [2:0] SRW_OP_REFRESH = 3'h6;

  typedef struct packed {
    logic valid;
    logic [2:0] op;
    logic area3;
    logic [1:0] bank;
    logic [12:0] row;
  } srw_cmd_req_s;

  typedef struct packed {
    logic valid;
    logic [2:0] op;
    logic [1:0] bank;
    logic [12:0] row;
  } srw_mem_cmd_s;

endpackage

/* verilog/srw_top.sv */
`timescale 1ns/1ns

// ****************************************
// Recovery wait counter
// ****************************************
module srw_rec_timer (
  // Clock and control
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Load and state
  input wire logic load_in,
  input wire logic [1:0] wait_in,
  output logic busy_out
);

  logic [1:0] count;

  // Load on the write, then count down to zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= 2'h0;
    end else if (ce_in) begin
      if (load_in) begin
        count <= wait_in;
      end else if (count != 2'h0) begin
        count <= count - 2'h1;
      end
    end
  end

  assign busy_out = (count != 2'h0);

endmodule

// ****************************************
// Write recovery and refresh timer block
// ****************************************
module srw_top
  import srw_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Command request from the controller sequencer
  input wire srw_cmd_req_s cmd_req_in,
  output logic cmd_ready_out,
  // Command toward the memory
  output srw_mem_cmd_s mem_cmd_out,
  // Refresh request to the controller
  output logic refresh_req_out
);

  logic rst_meta;
  logic rst_n;
  logic wr_pend;
  logic rd_pend;
  logic [7:0] addr_q;
  logic bus_acc;
  logic wr_en;
  logic [1:0] write_recovery_wait;
  logic [7:0] refresh_timer_counter;
  logic [7:0] refresh_constant;
  logic [2:0] refresh_clock_select;
  logic match_flag;
  logic [11:0] prescale;
  logic tick;
  logic timer_match;
  logic timer_wr;
  logic [31:0] rd_mux;
  logic issue;
  logic ap_busy;
  logic wr_busy;
  logic blocked;
  logic wr_ap_issue;
  logic wr_issue;

  // ****************************************
  // Reset release
  // ****************************************
  // Two stages so the release never meets a clock edge unsynchronised
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  assign bus_acc = hsel_in && htrans_in[SRW_HTRANS_ACT_BIT] && hready_in && ce_in;
  assign wr_en = wr_pend && ce_in;

  // Address phase capture; reads take one wait state
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 8'h00;
    end else if (ce_in) begin
      if (hready_in) begin
        wr_pend <= bus_acc && hwrite_in;
        rd_pend <= bus_acc && !hwrite_in;
        addr_q <= haddr_in[7:0];
      end else begin
        rd_pend <= 1'b0;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = SRW_RD_NONE;
    case (addr_q)
      SRW_OFS_CFG: begin
        rd_mux[SRW_WRW_MSB:SRW_WRW_LSB] = write_recovery_wait;
      end
      SRW_OFS_TIMER: begin
        rd_mux[SRW_CNT_MSB:0] = refresh_timer_counter;
      end
      SRW_OFS_CONST: begin
        rd_mux[SRW_CNT_MSB:0] = refresh_constant;
      end
      SRW_OFS_CTRL: begin
        rd_mux[SRW_CKS_MSB:SRW_CKS_LSB] = refresh_clock_select;
        rd_mux[SRW_FLAG_BIT] = match_flag;
      end
      default: begin
        rd_mux = SRW_RD_NONE;
      end
    endcase
  end

  // Read data sampled in the wait state, after any earlier write landed
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_out <= SRW_RD_NONE;
    end else if (ce_in && rd_pend) begin
      hrdata_out <= rd_mux;
    end
  end

  assign hreadyout_out = ce_in && !rd_pend;
  assign hresp_out = 1'b0;

  // ****************************************
  // Configuration registers
  // ****************************************
  // One recovery field, shared by both memory areas
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      write_recovery_wait <= SRW_WRW_RST;
    end else if (wr_en && addr_q == SRW_OFS_CFG) begin
      write_recovery_wait <= hwdata_in[SRW_WRW_MSB:SRW_WRW_LSB];
    end
  end

  // Refresh constant and clock select
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      refresh_constant <= SRW_CONST_RST;
      refresh_clock_select <= SRW_CKS_RST;
    end else if (wr_en) begin
      if (addr_q == SRW_OFS_CONST) begin
        refresh_constant <= hwdata_in[SRW_CNT_MSB:0];
      end
      if (addr_q == SRW_OFS_CTRL) begin
        refresh_clock_select <= hwdata_in[SRW_CKS_MSB:SRW_CKS_LSB];
      end
    end
  end

  // Match flag: write 0 clears, a match in the same cycle wins
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      match_flag <= 1'b0;
    end else if (ce_in) begin
      if (timer_match) begin
        match_flag <= 1'b1;
      end else if (wr_en && addr_q == SRW_OFS_CTRL && !hwdata_in[SRW_FLAG_BIT]) begin
        match_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // Refresh timer
  // ****************************************
  // Free-running prescaler; masks pick the step rate
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= 12'h000;
    end else if (ce_in) begin
      prescale <= prescale + 12'h001;
    end
  end

  assign tick = ce_in && (refresh_clock_select != SRW_CKS_STOP) &&
                ((prescale & SRW_PRE_MASK[refresh_clock_select]) ==
                 SRW_PRE_MASK[refresh_clock_select]);
  assign timer_match = tick && (refresh_timer_counter == refresh_constant);
  assign timer_wr = wr_en && (addr_q == SRW_OFS_TIMER) &&
                    (hwdata_in[31:SRW_KEY_LSB] == SRW_TIMER_KEY);

  // Keyed write beats counting; a bad key leaves the count alone
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      refresh_timer_counter <= SRW_CNT_RST;
    end else if (timer_wr) begin
      refresh_timer_counter <= hwdata_in[SRW_CNT_MSB:0];
    end else if (timer_match) begin
      refresh_timer_counter <= SRW_CNT_RST;
    end else if (tick) begin
      refresh_timer_counter <= refresh_timer_counter + 8'h01;
    end
  end

  // Refresh request pulse on each match
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      refresh_req_out <= 1'b0;
    end else if (ce_in) begin
      refresh_req_out <= timer_match;
    end
  end

  // ****************************************
  // Write recovery spacing
  // ****************************************
  // Separate counters so a plain write cannot cut short auto-precharge recovery
  assign blocked = (ap_busy && cmd_req_in.op == SRW_OP_ACTIVATE) ||
                   (wr_busy && cmd_req_in.op == SRW_OP_PRECHARGE);
  assign cmd_ready_out = ce_in && rst_n && !blocked;
  assign issue = cmd_req_in.valid && cmd_ready_out;
  assign wr_ap_issue = issue && cmd_req_in.op == SRW_OP_WRITE_AP;
  assign wr_issue = issue && cmd_req_in.op == SRW_OP_WRITE;

  srw_rec_timer u_ap_rec (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .load_in(wr_ap_issue),
    .wait_in(write_recovery_wait),
    .busy_out(ap_busy)
  );

  srw_rec_timer u_wr_rec (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .load_in(wr_issue),
    .wait_in(write_recovery_wait),
    .busy_out(wr_busy)
  );

  // Registered command toward the memory, one cycle per command
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mem_cmd_out <= '0;
    end else if (ce_in) begin
      mem_cmd_out.valid <= issue;
      mem_cmd_out.op <= issue ? cmd_req_in.op : SRW_OP_NOP;
      mem_cmd_out.bank <= cmd_req_in.bank;
      mem_cmd_out.row <= cmd_req_in.row;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n || !ce_in);

  logic row_activate_cmd_issue;
  logic pre_issue;
  assign row_activate_cmd_issue = issue && cmd_req_in.op == SRW_OP_ACTIVATE;
  assign pre_issue = issue && cmd_req_in.op == SRW_OP_PRECHARGE;

  chk_wait_one: assert property (
    wr_ap_issue && write_recovery_wait == 2'h1 |=> ap_busy ##1 !ap_busy)
    else $error("recovery code 01 not one cycle");
  chk_row_activate_cmd_hold: assert property (
    wr_ap_issue && write_recovery_wait == 2'h3 |=> !row_activate_cmd_issue [*3])
    else $error("activate inside auto-precharge recovery");
  chk_pre_hold: assert property (
    wr_issue && write_recovery_wait == 2'h2 |=> !pre_issue [*2] ##1 !wr_busy)
    else $error("precharge inside write recovery");
  chk_area_shared: assert property (
    wr_ap_issue && cmd_req_in.area3 && write_recovery_wait != 2'h0 |=> ap_busy)
    else $error("area 3 not using shared recovery");
  chk_cfg_rsvd: assert property (
    rd_pend && addr_q == SRW_OFS_CFG |=> hrdata_out[2] == 1'b0)
    else $error("reserved config bit read nonzero");
  chk_timer_step: assert property (
    tick && !timer_wr && !timer_match |=>
    refresh_timer_counter == $past(refresh_timer_counter) + 8'h01)
    else $error("timer did not step");
  chk_match_clear: assert property (
    timer_match && !timer_wr |=> refresh_timer_counter == 8'h00 && refresh_req_out)
    else $error("match did not clear timer");
  chk_timer_wrap: assert property (
    tick && !timer_wr && refresh_timer_counter == SRW_CNT_MAX |=>
    refresh_timer_counter == 8'h00)
    else $error("timer did not wrap");
  chk_key_write: assert property (
    timer_wr |=> refresh_timer_counter == $past(hwdata_in[7:0]))
    else $error("keyed timer write lost");
  chk_timer_rsvd: assert property (
    rd_pend && addr_q == SRW_OFS_TIMER |=> hrdata_out[31:8] == 24'h000000)
    else $error("timer upper bits read nonzero");
  chk_bad_key: assert property (
    wr_en && addr_q == SRW_OFS_TIMER && !timer_wr && !tick |=> $stable(refresh_timer_counter))
    else $error("unkeyed timer write took effect");

  cov_row_activate_cmd_after_ap: cover property (wr_ap_issue ##[1:4] row_activate_cmd_issue);
  cov_pre_after_wr: cover property (wr_issue ##[1:4] pre_issue);
  cov_match: cover property (timer_match);
  cov_bad_key: cover property (wr_en && addr_q == SRW_OFS_TIMER && !timer_wr);

endmodule

/* sim/srw_sdram_model.sv */
`timescale 1ns/1ns

// ****************************************
// Memory-side command spacing model
// ****************************************
module srw_sdram_model
  import srw_pkg::*;
(
  // Clock and commands seen by the memory
  input wire logic clk_in,
  input wire srw_mem_cmd_s mem_cmd_in,
  input wire logic [1:0] rec_in,
  // Observed spacing
  output int gap_out,
  output int bad_out
);
  int cyc = 0;
  int t_wap = -100;
  int t_wr = -100;

  // Memory needs its recovery time before activate or precharge
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (mem_cmd_in.valid === 1'b1) begin
      case (mem_cmd_in.op)
        SRW_OP_WRITE_AP: t_wap <= cyc;
        SRW_OP_WRITE: t_wr <= cyc;
        SRW_OP_ACTIVATE: begin
          gap_out <= cyc - t_wap;
          if (cyc - t_wap <= int'(rec_in)) bad_out <= bad_out + 1;
        end
        SRW_OP_PRECHARGE: begin
          gap_out <= cyc - t_wr;
          if (cyc - t_wr <= int'(rec_in)) bad_out <= bad_out + 1;
        end
        default: ;
      endcase
    end
  end
endmodule

/* sim/sdram_refresh_write_timing_bench.sv */
`timescale 1ns/1ns

module sdram_refresh_write_timing_bench;
  import srw_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata_out;
  logic hreadyout_out;
  logic hresp_out;
  srw_cmd_req_s cmd_req = '0;
  logic cmd_ready_out;
  srw_mem_cmd_s mem_cmd_out;
  logic refresh_req_out;
  logic [1:0] rec = '0;
  int gap;
  int bad;
  int failures = 0;
  int cmp_count = 0;
  integer seed;

  // Free running 100 MHz clock
  always #5 clk_in = ~clk_in;

  srw_top i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(1'b1), .hsel_in(1'b1),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .cmd_req_in(cmd_req),
    .cmd_ready_out(cmd_ready_out), .mem_cmd_out(mem_cmd_out),
    .refresh_req_out(refresh_req_out));

  srw_sdram_model i_mem (.clk_in(clk_in), .mem_cmd_in(mem_cmd_out), .rec_in(rec),
    .gap_out(gap), .bad_out(bad));

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task finish_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // Sampled at the falling edge so the rising edge sees the same value
  task wait_hi(input logic sel);
    int n;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while ((sel ? cmd_ready_out : hreadyout_out) !== 1'b1 && n < 100);
    if (n >= 100) begin
      chk(1'b0, "wait timed out");
      finish_test;
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_in);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_hi(1'b0);
    @(posedge clk_in);
    htrans <= 2'h0;
    hwdata <= d;
    wait_hi(1'b0);
    r = hrdata_out;
  endtask

  // Called just after a rising edge; request stays until taken
  task issue(input logic [2:0] op, input logic area);
    cmd_req <= '{valid: 1'b1, op: op, area3: area, bank: 2'h1, row: 13'h0};
    wait_hi(1'b1);
    @(posedge clk_in);
  endtask

  function automatic int exp_gap(input logic [1:0] n);
    return int'(n) + 1;
  endfunction

  // Earliest poll count that sees the refresh pulse; prescale phase adds up to p - 1
  function automatic int exp_lo(input int ticks, input int p);
    return (ticks - 1) * p + 2;
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] r;
    logic [31:0] d;
    logic [7:0] tv;
    logic [1:0] c;
    int n;
    int p;
    int t;
    seed = 32'hF5178B18;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    bus(1'b0, SRW_OFS_TIMER, 32'h0, r);
    chk(r === 32'h0, "timer reset value");
    bus(1'b0, SRW_OFS_CONST, 32'h0, r);
    chk(r[7:0] === SRW_CONST_RST, "constant reset value");
    chk(hresp_out === 1'b0, "bus response not okay");
    bus(1'b0, SRW_OFS_CFG, 32'h0, r);
    chk(r[4:2] === 3'h0, "config reset value");
    $display("test reset values done");
    // Every code once, then random codes; areas alternate
    for (int i = 0; i < 6; i++) begin
      c = (i < 4) ? i[1:0] : 2'($random(seed));
      bus(1'b1, SRW_OFS_CFG, {27'h0, c, 3'b000}, r);
      bus(1'b0, SRW_OFS_CFG, 32'h0, r);
      chk(r[4:2] === {c, 1'b0}, "recovery field or reserved bit");
      rec = c;
      @(posedge clk_in);
      issue(SRW_OP_WRITE_AP, i[0]);
      issue(SRW_OP_ACTIVATE, i[0]);
      cmd_req <= '0;
      repeat (2) @(negedge clk_in);
      chk(gap === exp_gap(c), "activate spacing");
      @(posedge clk_in);
      issue(SRW_OP_WRITE, ~i[0]);
      issue(SRW_OP_PRECHARGE, ~i[0]);
      cmd_req <= '0;
      repeat (2) @(negedge clk_in);
      chk(gap === exp_gap(c), "precharge spacing");
    end
    chk(bad === 0, "memory saw an early command");
    $display("test write recovery done");
    // Timer stopped: odd passes keyed, even passes a wrong key
    tv = 8'h00;
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      if (i[0]) d[31:16] = SRW_TIMER_KEY;
      else if (d[31:16] === SRW_TIMER_KEY) d[16] = ~d[16];
      bus(1'b1, SRW_OFS_TIMER, d, r);
      if (i[0]) tv = d[7:0];
      bus(1'b0, SRW_OFS_TIMER, 32'h0, r);
      chk(r === {24'h0, tv}, "timer keyed write");
    end
    $display("test timer protection done");
    // Start at 200, wrap past 255, then match at 3
    bus(1'b1, SRW_OFS_CONST, 32'h3, r);
    bus(1'b1, SRW_OFS_TIMER, {SRW_TIMER_KEY, 16'h00C8}, r);
    bus(1'b1, SRW_OFS_CTRL, 32'h8, r);
    n = 0;
    while (refresh_req_out !== 1'b1 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    // Select code 1 steps once per prescale period; 200 to 3 through 255 is 60 ticks
    p = int'(SRW_PRE_MASK[1]) + 1;
    t = ((32'h3 - 32'hC8) & 32'hFF) + 1;
    chk(n >= exp_lo(t, p) && n <= exp_lo(t, p) + p - 1, "wrap then match timing");
    bus(1'b0, SRW_OFS_TIMER, 32'h0, r);
    // Next tick lands after the read samples, so the cleared value is seen
    chk(r === 32'h0, "timer cleared on match");
    $display("test timer count done");
    finish_test;
  end
endmodule
